//--- hw/liu_diag_pkg.sv
/*
 Constants and types for the per-channel diagnostic and de-jitter control block.
 Assumes a single 20 MHz clock domain and one channel per instance.
*/
package liu_diag_pkg;
   // Register map and field positions
   localparam logic [7:0] DJ_CTRL_OFFSET  = 8'h07;
   localparam int         DJ_CFG_LO_BIT   = 0;
   localparam int         DJ_PATH_BIT     = 1;
   localparam int         DJ_CFG_HI_BIT   = 2;
   localparam int         DJ_FLUSH_BIT    = 3;
   localparam logic [3:0] DJ_CTRL_RESET   = 4'h0;
   localparam logic [3:0] DJ_UNUSED_READ  = 4'h0;
   // De-jitter FIFO
   localparam int         DJ_MEM_WORDS    = 32;
   localparam logic [5:0] DJ_DEPTH_SHORT  = 6'h10;
   localparam logic [5:0] DJ_DEPTH_LONG   = 6'h20;
   // Pattern generator and checker
   localparam logic [22:0] PRBS_SEED      = 23'h7FFFFF;
   localparam logic [5:0]  CHK_LOCK_BITS  = 6'h20;
   localparam logic [2:0]  CHK_LOSS_ERRS  = 3'h4;
   // Receive output buffer
   localparam logic [1:0]  RXB_DEPTH      = 2'h2;

   typedef enum logic [1:0] {LB_NONE, LB_ANALOG, LB_REMOTE, LB_DIGITAL} loop_t;
   typedef enum logic {CHK_HUNT, CHK_SYNC} chk_state_t;
endpackage

//--- hw/liu_channel_diag_dejitter_ctrl.sv
/*
 One channel of diagnostic and de-jitter control: control register, de-jitter
 FIFO, pattern generator and checker, analog loopback and a two-entry receive
 output buffer. Assumes control inputs come from logic on the same clock and
 that the receive line pins are asynchronous and need synchronising.
*/
// Functional notes
// (RL1) Rising write of flush bit resets de-jitter
// (RL2) Flush returns FIFO pointers to zero
// (RL3) Flush discards all FIFO contents
// (RL4) Software clears flush bit to resume
// (RL5) Config bits: 16, 32 deep, or disabled
// (RL6) Path bit: receive when 0, transmit 1
// (RL7) Pattern test only in host mode
// (RL8) Pattern 2^23-1 in E3, else 2^15-1
// (RL9) Checker enabled together with generator
// (RL10) Negative output low once pattern synced
// (RL11) Unsynced: sync-lost set, negative output high
// (RL12) Inject write corrupts exactly one bit
// (RL13) Software rewrites zero before next inject
// (RL14) Each detected error pulses output one cycle
// (RL15) Pattern test forces single-rail operation
// (RL16) Loopback chosen by remote, local selects
// (RL17) Analog loop feeds transmit into receive
// (RL18) Analog loop passes through assigned de-jitter
// (RL19) Analog loop still drives transmit line
// (RL20) Analog loop ignores external receive line
// (RL21) Single rail: negative output flags violations
// (RL22) E3 select picks the longer pattern
// (RL23) Upper four control bits read zero
`timescale 1ns/1ps
module liu_channel_diag_dejitter_ctrl (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Register port
   input  wire logic       reg_wr_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wr_data,
   output logic      [7:0] reg_rd_data,
   // Channel control
   input  wire logic       host_mode,
   input  wire logic       pattern_test_enable,
   input  wire logic       pattern_error_inject,
   input  wire logic       e3_rate_select,
   input  wire logic       rail_mode_select,
   input  wire logic       remote_loop_select,
   input  wire logic       local_loop_select,
   output logic            pattern_sync_lost,
   // Transmit stream
   input  wire logic       tx_valid,
   input  wire logic       tx_pos,
   input  wire logic       tx_neg,
   output logic            tx_ready,
   // Line
   output logic            tx_line_pos,
   output logic            tx_line_neg,
   input  wire logic       rx_line_pos,
   input  wire logic       rx_line_neg,
   // Receive stream
   output logic            rx_recovered_clk,
   output logic            rx_pos_data,
   output logic            rx_neg_or_violation,
   output logic            rx_out_valid,
   input  wire logic       rx_out_ready
);

   function automatic logic prbs_bit(input logic [22:0] s, input logic e3);
      prbs_bit = e3 ? (s[22] ^ s[17]) : (s[14] ^ s[13]);
   endfunction

   function automatic logic [4:0] next_ptr(input logic [4:0] p, input logic [5:0] depth);
      logic [5:0] n;
      n = {1'b0, p} + 6'h01;
      next_ptr = (n == depth) ? 5'h00 : n[4:0];
   endfunction

   function automatic liu_diag_pkg::loop_t loop_decode(input logic rlb, input logic llb);
      loop_decode = liu_diag_pkg::loop_t'({rlb, llb});
   endfunction

   // Control register
   logic [3:0] ctrl_q, ctrl_d;
   logic [7:0] rd_q, rd_d;
   logic       addr_hit, flush_now;

   always_comb begin
      addr_hit  = (reg_addr == liu_diag_pkg::DJ_CTRL_OFFSET);
      ctrl_d    = ctrl_q;
      flush_now = 1'b0;
      if (reg_wr_en && addr_hit) begin
         ctrl_d    = reg_wr_data[3:0]; // RL23
         flush_now = reg_wr_data[liu_diag_pkg::DJ_FLUSH_BIT]
                     & ~ctrl_q[liu_diag_pkg::DJ_FLUSH_BIT]; // RL1
      end
      rd_d = addr_hit ? {liu_diag_pkg::DJ_UNUSED_READ, ctrl_q} : 8'h00; // RL23
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_q <= liu_diag_pkg::DJ_CTRL_RESET;
         rd_q   <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         rd_q   <= rd_d;
      end
   end

   // Decoded modes
   logic       dj_enable, dj_in_tx, dj_hold, pattern_on, single_rail, analog, step;
   logic [5:0] dj_depth;
   logic       space_q;

   always_comb begin
      dj_enable   = ~ctrl_q[liu_diag_pkg::DJ_CFG_LO_BIT]; // RL5
      dj_depth    = ctrl_q[liu_diag_pkg::DJ_CFG_HI_BIT] ? liu_diag_pkg::DJ_DEPTH_LONG
                                                         : liu_diag_pkg::DJ_DEPTH_SHORT; // RL5
      dj_in_tx    = ctrl_q[liu_diag_pkg::DJ_PATH_BIT]; // RL6
      // Held in flush until software clears the bit
      dj_hold     = flush_now | ctrl_q[liu_diag_pkg::DJ_FLUSH_BIT]; // RL4
      pattern_on  = host_mode & pattern_test_enable; // RL7 RL9
      single_rail = rail_mode_select | pattern_on; // RL15
      analog      = (loop_decode(remote_loop_select, local_loop_select)
                     == liu_diag_pkg::LB_ANALOG); // RL16
      // Every stage after the receive synchroniser advances only when the receive buffer has room
      step        = space_q;
   end

   // Receive line synchroniser
   logic [1:0] sync1_q, sync2_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= {rx_line_pos, rx_line_neg};
         sync2_q <= sync1_q;
      end
   end

   // Transmit source, generator and error insertion
   logic [22:0] gen_q, gen_d;
   logic        ami_q, ami_d, inj_prev_q, inj_pend_q, inj_pend_d;
   logic        gen_bit, tx_data;
   logic [1:0]  tx_enc;

   always_comb begin
      gen_bit = prbs_bit(gen_q, e3_rate_select); // RL8 RL22
      if (pattern_on) begin
         tx_data = gen_bit ^ inj_pend_q; // RL12
      end else begin
         tx_data = tx_valid & tx_pos;
      end
      if (single_rail) begin
         tx_enc = {tx_data & ~ami_q, tx_data & ami_q};
      end else begin
         tx_enc = tx_valid ? {tx_pos, tx_neg} : 2'h0;
      end
      ami_d = (step && single_rail && tx_data) ? ~ami_q : ami_q;
      gen_d = (step && pattern_on) ? {gen_q[21:0], gen_bit} : gen_q; // RL8
      // A new request wins over the consumption of an older one
      inj_pend_d = (inj_pend_q & ~(step & pattern_on))
                   | (pattern_on & pattern_error_inject & ~inj_prev_q); // RL12 RL13
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         gen_q      <= liu_diag_pkg::PRBS_SEED;
         ami_q      <= 1'b0;
         inj_prev_q <= 1'b0;
         inj_pend_q <= 1'b0;
      end else begin
         gen_q      <= gen_d;
         ami_q      <= ami_d;
         inj_prev_q <= pattern_error_inject;
         inj_pend_q <= inj_pend_d;
      end
   end

   // De-jitter FIFO, shared by whichever path it is assigned to
   logic [1:0] dj_mem [liu_diag_pkg::DJ_MEM_WORDS];
   logic [4:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [5:0] cnt_q, cnt_d;
   logic       primed_q, primed_d, push, pop;
   logic [1:0] fifo_in, fifo_out, rx_src, rx_after, tx_line_q, tx_line_d;

   always_comb begin
      rx_src   = analog ? tx_line_q : sync2_q; // RL17 RL20
      fifo_in  = dj_in_tx ? tx_enc : rx_src; // RL6 RL18
      push     = step & dj_enable;
      pop      = push & primed_q;
      fifo_out = primed_q ? dj_mem[rd_ptr_q] : 2'h0;
      wr_ptr_d = push ? next_ptr(wr_ptr_q, dj_depth) : wr_ptr_q;
      rd_ptr_d = pop ? next_ptr(rd_ptr_q, dj_depth) : rd_ptr_q;
      cnt_d    = (push && !pop) ? cnt_q + 6'h01 : cnt_q;
      // Reading starts half full so the FIFO can absorb wander both ways
      primed_d = primed_q | (push && ((cnt_q + 6'h01) >= {1'b0, dj_depth[5:1]})); // RL5
      if (dj_hold || !dj_enable) begin
         wr_ptr_d = 5'h00; // RL2
         rd_ptr_d = 5'h00; // RL2
         cnt_d    = 6'h00; // RL3
         primed_d = 1'b0; // RL3
      end
      tx_line_d = tx_line_q;
      if (step) begin
         tx_line_d = (dj_enable && dj_in_tx) ? fifo_out : tx_enc; // RL19
      end
      rx_after = (dj_enable && !dj_in_tx) ? fifo_out : rx_src; // RL18
   end

   always_ff @(posedge clock) begin
      if (push && !dj_hold) begin
         dj_mem[wr_ptr_q] <= fifo_in;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ptr_q  <= 5'h00;
         rd_ptr_q  <= 5'h00;
         cnt_q     <= 6'h00;
         primed_q  <= 1'b0;
         tx_line_q <= 2'h0;
      end else begin
         wr_ptr_q  <= wr_ptr_d;
         rd_ptr_q  <= rd_ptr_d;
         cnt_q     <= cnt_d;
         primed_q  <= primed_d;
         tx_line_q <= tx_line_d;
      end
   end

   // Pattern checker and receive rail formatting
   liu_diag_pkg::chk_state_t chk_q, chk_d;
   logic [22:0] chk_sr_q, chk_sr_d;
   logic [5:0]  run_q, run_d;
   logic [2:0]  errs_q, errs_d;
   logic        last_pos_q, last_pos_d, last_neg_q, last_neg_d;
   logic        rx_bit, mismatch, viol, lost_d, lost_q;
   logic [1:0]  rx_word;

   always_comb begin
      rx_bit     = rx_after[1] | rx_after[0];
      mismatch   = rx_bit ^ prbs_bit(chk_sr_q, e3_rate_select); // RL9
      chk_sr_d   = (step && pattern_on) ? {chk_sr_q[21:0], rx_bit} : chk_sr_q;
      chk_d      = chk_q;
      run_d      = run_q;
      errs_d     = errs_q;
      if (!pattern_on) begin
         chk_d  = liu_diag_pkg::CHK_HUNT;
         run_d  = 6'h00;
         errs_d = 3'h0;
      end else if (step) begin
         unique case (chk_q)
            liu_diag_pkg::CHK_HUNT: begin
               run_d = mismatch ? 6'h00 : run_q + 6'h01;
               if (!mismatch && run_q == liu_diag_pkg::CHK_LOCK_BITS - 6'h01) begin
                  chk_d  = liu_diag_pkg::CHK_SYNC;
                  run_d  = 6'h00;
                  errs_d = 3'h0;
               end
            end
            liu_diag_pkg::CHK_SYNC: begin
               if (mismatch) begin
                  errs_d = errs_q + 3'h1;
                  if (errs_d == liu_diag_pkg::CHK_LOSS_ERRS) begin
                     chk_d = liu_diag_pkg::CHK_HUNT;
                     run_d = 6'h00;
                  end
               end else if (run_q == liu_diag_pkg::CHK_LOCK_BITS - 6'h01) begin
                  run_d  = 6'h00;
                  errs_d = 3'h0;
               end else begin
                  run_d = run_q + 6'h01;
               end
            end
         endcase
      end
      lost_d = (chk_d != liu_diag_pkg::CHK_SYNC); // RL11
      // Violation: two pulses in a row of the same polarity
      viol       = (rx_after[1] & last_pos_q) | (rx_after[0] & last_neg_q);
      last_pos_d = last_pos_q;
      last_neg_d = last_neg_q;
      if (step && rx_bit) begin
         last_pos_d = rx_after[1];
         last_neg_d = rx_after[0];
      end
      if (pattern_on) begin
         rx_word = {rx_bit, (chk_q != liu_diag_pkg::CHK_SYNC) | mismatch}; // RL10 RL11 RL14
      end else if (single_rail) begin
         rx_word = {rx_bit, viol}; // RL21
      end else begin
         rx_word = rx_after;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         chk_q      <= liu_diag_pkg::CHK_HUNT;
         chk_sr_q   <= 23'h000000;
         run_q      <= 6'h00;
         errs_q     <= 3'h0;
         last_pos_q <= 1'b0;
         last_neg_q <= 1'b0;
         lost_q     <= 1'b1;
      end else begin
         chk_q      <= chk_d;
         chk_sr_q   <= chk_sr_d;
         run_q      <= run_d;
         errs_q     <= errs_d;
         last_pos_q <= last_pos_d;
         last_neg_q <= last_neg_d;
         lost_q     <= lost_d;
      end
   end

   // Two-entry receive buffer; a stalled receiver stalls every stage after the receive synchroniser
   logic [1:0] b0_q, b0_d, b1_q, b1_d, bcnt_q, bcnt_d;
   logic       bpop, valid_q, valid_d, space_d, rclk_q, rclk_d;

   always_comb begin
      bpop   = (bcnt_q != 2'h0) & rx_out_ready;
      b0_d   = b0_q;
      b1_d   = b1_q;
      bcnt_d = bcnt_q;
      if (bpop) begin
         b0_d   = b1_q;
         bcnt_d = bcnt_q - 2'h1;
      end
      if (step) begin
         if (bcnt_d == 2'h0) begin
            b0_d = rx_word;
         end else begin
            b1_d = rx_word;
         end
         bcnt_d = bcnt_d + 2'h1;
      end
      valid_d = (bcnt_d != 2'h0);
      space_d = (bcnt_d < liu_diag_pkg::RXB_DEPTH);
      rclk_d  = bpop ? ~rclk_q : rclk_q;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         b0_q    <= 2'h0;
         b1_q    <= 2'h0;
         bcnt_q  <= 2'h0;
         valid_q <= 1'b0;
         space_q <= 1'b1;
         rclk_q  <= 1'b0;
      end else begin
         b0_q    <= b0_d;
         b1_q    <= b1_d;
         bcnt_q  <= bcnt_d;
         valid_q <= valid_d;
         space_q <= space_d;
         rclk_q  <= rclk_d;
      end
   end

   assign reg_rd_data         = rd_q;
   assign pattern_sync_lost   = lost_q;
   assign tx_ready            = space_q;
   assign tx_line_pos         = tx_line_q[1];
   assign tx_line_neg         = tx_line_q[0];
   assign rx_recovered_clk    = rclk_q;
   assign rx_pos_data         = b0_q[1];
   assign rx_neg_or_violation = b0_q[0];
   assign rx_out_valid        = valid_q;

endmodule

//--- sim/liu_diag_sva.sv
/*
 Port assertions for one channel of diagnostic and de-jitter control.
 Assumes a bind onto liu_channel_diag_dejitter_ctrl in the single clock domain.
*/
`timescale 1ns/1ps
module liu_diag_sva (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset,
   // Register port
   input wire logic       reg_wr_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   // Control and status
   input wire logic       host_mode,
   input wire logic       pattern_test_enable,
   input wire logic       rail_mode_select,
   input wire logic       pattern_sync_lost,
   // Streams and line
   input wire logic       tx_ready,
   input wire logic       tx_line_pos,
   input wire logic       tx_line_neg,
   input wire logic       rx_recovered_clk,
   input wire logic       rx_pos_data,
   input wire logic       rx_neg_or_violation,
   input wire logic       rx_out_valid,
   input wire logic       rx_out_ready
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   a_reset_values: assert property (disable iff (1'h0) reset |=> pattern_sync_lost
      && tx_ready && reg_rd_data == 8'h00 && !rx_out_valid) else $error("bad state after reset");
   a_upper_zero: assert property (reg_rd_data[7:4] == 4'h0) else $error("upper bits set");
   a_unmapped_read: assert property (reg_addr != 8'h07 |=> reg_rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_write_readback: assert property ((reg_wr_en && reg_addr == 8'h07) ##1
      (!reg_wr_en && reg_addr == 8'h07) |=> reg_rd_data[3:0] == $past(reg_wr_data[3:0], 2))
      else $error("readback differs");
   a_host_only: assert property (!host_mode [*3] |-> pattern_sync_lost)
      else $error("pattern active outside host mode");
   // Eight ready cycles flush any word queued before the status changed
   a_unsync_flag: assert property ((host_mode && pattern_test_enable && pattern_sync_lost
      && rx_out_ready) [*8] ##0 rx_out_valid ##1 pattern_sync_lost |-> $past(rx_neg_or_violation))
      else $error("unsynced word not flagged");
   a_stall_hold: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid
      && $stable(rx_pos_data) && $stable(rx_neg_or_violation)) else $error("head changed");
   a_clock_toggle: assert property (rx_out_valid && rx_out_ready |=> $changed(rx_recovered_clk))
      else $error("receive clock did not toggle");
   a_ready_room: assert property (rx_out_ready [*3] |-> tx_ready) else $error("step refused");
   // Dual rail passes both input rails through, so only single-rail steps are checked
   a_line_exclusive: assert property ((rail_mode_select || host_mode && pattern_test_enable)
      && tx_ready |=> !(tx_line_pos && tx_line_neg)) else $error("both rails");

   c_synced: cover property (host_mode && pattern_test_enable && !pattern_sync_lost);
   c_full: cover property (rx_out_valid && !rx_out_ready && !tx_ready);
   c_write: cover property (reg_wr_en && reg_addr == 8'h07);
endmodule

bind liu_channel_diag_dejitter_ctrl liu_diag_sva i_sva (.*);

//--- sim/rx_sink_model.sv
/*
 Receive-side sink standing in for the framing equipment.
 Assumes the bench drives stall and slow just after a clock edge.
*/
`timescale 1ns/1ps
module rx_sink_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Bench control
   input  wire logic stall,
   input  wire logic slow,
   // Receive stream
   input  wire logic rx_out_valid,
   input  wire logic rx_neg_or_violation,
   output logic      rx_out_ready,
   output int        viol_words
);
   logic phase_q;
   // Slow mode takes a word every other cycle so the buffer sees back-pressure
   always_ff @(posedge clock) begin
      phase_q      <= reset ? 1'h0 : ~phase_q;
      rx_out_ready <= !reset && !stall && (!slow || phase_q);
      if (reset)
         viol_words <= 0;
      else if (rx_out_valid && rx_out_ready && rx_neg_or_violation)
         viol_words <= viol_words + 1;
   end
endmodule

//--- sim/tb_top.sv
/*
 Self-checking bench for one channel block, with random line noise.
 Assumes the checker and the sink model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   logic       clock = 1'h0, reset = 1'h1, reg_wr_en = 1'h0, host_mode = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
   logic       pattern_test_enable = 1'h0, pattern_error_inject = 1'h0, e3_rate_select = 1'h0;
   logic       rail_mode_select = 1'h0, remote_loop_select = 1'h0, local_loop_select = 1'h0;
   logic       tx_valid = 1'h0, tx_pos = 1'h0, tx_neg = 1'h0, rx_line_pos = 1'h0;
   logic       rx_line_neg = 1'h0, stall = 1'h0, slow = 1'h0, collect = 1'h0, prev_step = 1'h0;
   logic       pattern_sync_lost, tx_ready, tx_line_pos, tx_line_neg, rx_recovered_clk;
   logic       rx_pos_data, rx_neg_or_violation, rx_out_valid, rx_out_ready, last_pos = 1'h0;
   logic       have_last = 1'h0;
   logic       bits[$];
   int         viol_words, ami_err = 0, seed = 32'h105608C0, miscompares = 0, compares = 0;

   liu_channel_diag_dejitter_ctrl i_dut (.*);
   rx_sink_model i_sink (.*);

   always #25 clock = ~clock;

   // Noise on the receive pins must never reach the outputs in analog loop
   always @(posedge clock) begin
      {tx_valid, tx_pos, tx_neg, rx_line_pos, rx_line_neg} <= 5'($random(seed));
      if (collect && prev_step) begin
         bits.push_back(tx_line_pos | tx_line_neg);
         if (tx_line_pos | tx_line_neg) begin
            if (have_last && tx_line_pos === last_pos) ami_err++;
            last_pos = tx_line_pos;
            have_last = 1'h1;
         end
      end else if (!collect) begin
         // Pulses sent between captures are not seen, so polarity tracking restarts
         have_last = 1'h0;
      end
      prev_step <= tx_ready;
   end

   task automatic stop_test;
      if (miscompares == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr_en <= 1'h1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge clock);
      reg_wr_en <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      repeat (2) @(posedge clock);
      chk(reg_rd_data, exp);
   endtask

   task automatic wait_sync(input logic lvl);
      int i;
      for (i = 0; i < 4000 && pattern_sync_lost !== lvl; i++) @(posedge clock);
      if (i == 4000) begin
         miscompares++;
         stop_test;
      end
   endtask

   // The checker follows a rate change at once, so sync is broken by leaving pattern mode
   task automatic resync;
      pattern_test_enable <= 1'h0;
      wait_sync(1'h1);
      pattern_test_enable <= 1'h1;
      wait_sync(1'h0);
   endtask

   task automatic grab(input int n);
      int i;
      bits.delete();
      collect <= 1'h1;
      for (i = 0; i < 20 * n && bits.size() < n; i++) @(posedge clock);
      collect <= 1'h0;
      chk(bits.size() >= n, 1);
   endtask

   // Breaks of the pattern recurrence b[n] = b[n-a] ^ b[n-b]
   function automatic int viol(input int a, input int b, input int from);
      int v = 0;
      for (int n = from; n < bits.size(); n++) if (bits[n] !== (bits[n-a] ^ bits[n-b])) v++;
      return v;
   endfunction

   function automatic int lead0();
      int n = 0;
      while (n < bits.size() && bits[n] === 1'h0) n++;
      return n;
   endfunction

   initial begin
      logic [7:0] w;
      int         base;
      repeat (16) @(posedge clock);
      reset <= 1'h0;
      @(posedge clock);
      chk(pattern_sync_lost, 1);
      for (int k = 0; k < 6; k++) begin
         w = (k == 0) ? 8'hFF : 8'($random(seed));
         wr(8'h07, w);
         rd(8'h07, {4'h0, w[3:0]});
      end
      wr(8'h17, 8'h00);
      rd(8'h17, 8'h00);
      rd(8'h07, {4'h0, w[3:0]});
      wr(8'h07, 8'h01);
      pattern_test_enable <= 1'h1;
      local_loop_select <= 1'h1;
      repeat (300) @(posedge clock);
      chk(pattern_sync_lost, 1);
      host_mode <= 1'h1;
      wait_sync(1'h0);
      // Words queued before lock still carry the unsynced flag
      repeat (4) @(posedge clock);
      base = viol_words;
      grab(300);
      chk(viol(15, 14, 15), 0);
      chk(viol_words - base, 0);
      pattern_error_inject <= 1'h1;
      grab(300);
      chk(viol(15, 14, 15) inside {[1:3]}, 1);
      chk(viol_words > base, 1);
      chk(pattern_sync_lost, 0);
      grab(300);
      chk(viol(15, 14, 15), 0);
      pattern_error_inject <= 1'h0;
      slow <= 1'h1;
      e3_rate_select <= 1'h1;
      resync;
      grab(300);
      chk(viol(23, 18, 23), 0);
      slow <= 1'h0;
      stall <= 1'h1;
      for (int i = 0; i < 20 && tx_ready !== 1'h0; i++) @(posedge clock);
      chk({tx_ready, rx_out_valid}, 2'h1);
      stall <= 1'h0;
      e3_rate_select <= 1'h0;
      resync;
      for (int k = 0; k < 2; k++) begin
         wr(8'h07, k ? 8'h0E : 8'h0A);
         repeat (40) @(posedge clock);
         grab(20);
         chk(lead0(), 20);
         wr(8'h07, k ? 8'h06 : 8'h02);
         grab(200);
         chk(lead0() >= (k ? 14 : 6), 1);
         chk(viol(15, 14, 40), 0);
      end
      wr(8'h07, 8'h08);
      wr(8'h07, 8'h00);
      repeat (100) @(posedge clock);
      wait_sync(1'h0);
      repeat (4) @(posedge clock);
      base = viol_words;
      grab(100);
      chk(viol_words - base, 0);
      pattern_test_enable <= 1'h0;
      rail_mode_select <= 1'h1;
      repeat (10) @(posedge clock);
      base = viol_words;
      repeat (200) @(posedge clock);
      chk(viol_words - base, 0);
      chk(ami_err, 0);
      stop_test;
   end

   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      stop_test;
   end
endmodule
